// ### hw/slpcg_defs.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef SLPCG_DEFS_SVH
`define SLPCG_DEFS_SVH
// Register indices as printed and byte addresses (0x010 plus index times four for the gate registers)
`define SLPCG_IDX_SLEEP_CTRL 8'h00
`define SLPCG_IDX_GEN_GATE 8'h00
`define SLPCG_IDX_ANA_GATE 8'h01
`define SLPCG_ADDR_SLEEP_CTRL 12'h000
`define SLPCG_ADDR_GEN_GATE 12'h010
`define SLPCG_ADDR_ANA_GATE 12'h014
`define SLPCG_ADDR_STATUS 12'h020
// Field positions
`define SLPCG_SEN_BIT 0
`define SLPCG_MODE_LSB 1
`define SLPCG_MODE_MSB 3
`define SLPCG_GEN_DMA 0
`define SLPCG_GEN_EVT 1
`define SLPCG_GEN_RTC 2
`define SLPCG_GEN_AES 4
`define SLPCG_GEN_USB 6
`define SLPCG_ANA_CMP 0
`define SLPCG_ANA_ADC 1
// Writable masks; other bits reserved, read zero
`define SLPCG_CTRL_MASK 8'h0F
`define SLPCG_GEN_MASK 8'h57
`define SLPCG_ANA_MASK 8'h03
`define SLPCG_RESET_VAL 8'h00
// Mode codes
`define SLPCG_IDLE_CODE 3'h0
`define SLPCG_POWER_DOWN_CODE 3'h2
`define SLPCG_POWER_SAVE_CODE 3'h3
`define SLPCG_STANDBY_CODE 3'h6
`define SLPCG_EXTENDED_STANDBY_CODE 3'h7
// Wake hold: four CPU cycles
`define SLPCG_WAKE_HOLD_CYCLES 3'h4
`endif

// ### hw/slpcg_pkg.sv
// Types for the sleep and clock gating block
package slpcg_pkg;
    typedef enum logic [1:0]
    {
        SLPCG_ACTIVE = 2'b00,
        SLPCG_SLEEP = 2'b01,
        SLPCG_WAKE = 2'b10
    } slpcg_state_type;

    // Clock enables handed to the clock domains and peripherals
    typedef struct packed
    {
        logic cpu;
        logic per;
        logic rtc_bus;
        logic rtc_src;
        logic sys_src;
        logic usb;
        logic aes;
        logic evt;
        logic dma;
        logic adc;
        logic cmp;
    } slpcg_clken_type;

    typedef struct packed
    {
        slpcg_state_type state;
        logic [7:0] sleep_ctrl;
        logic [7:0] gen_gate;
        logic [7:0] ana_gate;
        logic [2:0] mode;
        logic [2:0] hold_cnt;
        slpcg_clken_type clken;
        logic adc_off;
        logic cmp_off;
        logic vref_keep;
        logic bod_sampled;
        logic inbuf_en;
        logic asleep;
        logic pready;
        logic [31:0] prdata;
    } slpcg_state_all_type;
endpackage : slpcg_pkg

// ### hw/slpcg_top.sv
// Sleep mode controller and peripheral clock gating with APB registers
`include "slpcg_defs.svh"

module slpcg_top #(
    parameter int HOLD_CYCLES = 4
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Core and system side (same clock domain)
    input wire logic sleep_instr,
    input wire logic dma_enabled,
    input wire logic cmp_uses_vref,
    input wire logic debug_enabled,
    input wire logic irq_any,
    input wire logic irq_async_port,
    input wire logic irq_addr_match,
    input wire logic irq_usb_resume,
    input wire logic irq_rtc,
    // Clock enables and power controls
    output slpcg_pkg::slpcg_clken_type clken,
    output logic adc_force_off,
    output logic cmp_force_off,
    output logic vref_keep_on,
    output logic bod_sampled,
    output logic pin_inbuf_en,
    output logic asleep
);
    slpcg_pkg::slpcg_state_all_type st_r;
    slpcg_pkg::slpcg_state_all_type st_nxt;

    // Helper for decoding the selected mode
    function automatic logic mode_valid(input logic [2:0] m);
        mode_valid = (m == `SLPCG_IDLE_CODE) ||
            (m == `SLPCG_POWER_DOWN_CODE) ||
            (m == `SLPCG_POWER_SAVE_CODE) ||
            (m == `SLPCG_STANDBY_CODE) ||
            (m == `SLPCG_EXTENDED_STANDBY_CODE);
    endfunction : mode_valid

    logic access;
    logic [7:0] wbyte;
    logic [2:0] sel_mode;
    logic wake;
    logic in_sleep;
    logic idle_m;
    logic deep_m;
    logic keep_sys;
    logic keep_rtc;
    logic per_run;

    // Bus phase and byte 0 data
    assign access = psel && penable;
    assign wbyte = pwdata[7:0];
    assign sel_mode = st_r.sleep_ctrl[`SLPCG_MODE_MSB:`SLPCG_MODE_LSB];

    // Mode-dependent clock policy of the latched mode
    assign in_sleep = (st_r.state == slpcg_pkg::SLPCG_SLEEP);
    assign idle_m = (st_r.mode == `SLPCG_IDLE_CODE);
    assign deep_m = in_sleep && !idle_m;
    assign keep_sys = (st_r.mode == `SLPCG_STANDBY_CODE) ||
        (st_r.mode == `SLPCG_EXTENDED_STANDBY_CODE) ||
        idle_m || debug_enabled;
    assign keep_rtc = (st_r.mode == `SLPCG_POWER_SAVE_CODE) ||
        (st_r.mode == `SLPCG_EXTENDED_STANDBY_CODE) ||
        idle_m;

    // Wake sources allowed by the latched mode
    always_comb
    begin
        wake = irq_async_port || irq_addr_match || irq_usb_resume;
        if (idle_m)
        begin
            wake = wake || irq_any || irq_rtc;
        end
        else if (keep_rtc)
        begin
            wake = wake || irq_rtc;
        end
    end

    // Next state of every register
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.pready = 1'b0;
        st_nxt.prdata = 32'h0000_0000;
        // Register reads, one cycle access
        if (psel && !penable)
        begin
            st_nxt.pready = 1'b1;
            case (paddr)
                `SLPCG_ADDR_SLEEP_CTRL:
                    st_nxt.prdata = {24'h00_0000, st_r.sleep_ctrl};
                `SLPCG_ADDR_GEN_GATE:
                    st_nxt.prdata = {24'h00_0000, st_r.gen_gate};
                `SLPCG_ADDR_ANA_GATE:
                    st_nxt.prdata = {24'h00_0000, st_r.ana_gate};
                `SLPCG_ADDR_STATUS:
                    st_nxt.prdata = {28'h000_0000, st_r.mode,
                        st_r.asleep};
                default:
                    st_nxt.prdata = 32'h0000_0000;
            endcase
        end
        if (access && st_r.pready && pwrite && pstrb[0])
        begin
            case (paddr)
                `SLPCG_ADDR_SLEEP_CTRL:
                    st_nxt.sleep_ctrl = wbyte & `SLPCG_CTRL_MASK;
                `SLPCG_ADDR_GEN_GATE:
                begin
                    st_nxt.gen_gate = wbyte & `SLPCG_GEN_MASK;
                    // DMA gate may rise only while DMA is off
                    if (dma_enabled && !st_r.gen_gate[`SLPCG_GEN_DMA])
                    begin
                        st_nxt.gen_gate[`SLPCG_GEN_DMA] = 1'b0;
                    end
                end
                `SLPCG_ADDR_ANA_GATE:
                    st_nxt.ana_gate = wbyte & `SLPCG_ANA_MASK;
                default:
                    st_nxt.sleep_ctrl = st_r.sleep_ctrl;
            endcase
        end
        // Sleep sequencing
        case (st_r.state)
            slpcg_pkg::SLPCG_ACTIVE:
            begin
                if (sleep_instr && st_r.sleep_ctrl[`SLPCG_SEN_BIT] &&
                    mode_valid(sel_mode))
                begin
                    st_nxt.state = slpcg_pkg::SLPCG_SLEEP;
                    st_nxt.mode = sel_mode;
                end
            end
            slpcg_pkg::SLPCG_SLEEP:
            begin
                if (wake)
                begin
                    st_nxt.state = slpcg_pkg::SLPCG_WAKE;
                    st_nxt.hold_cnt = 3'(HOLD_CYCLES - 1);
                end
            end
            slpcg_pkg::SLPCG_WAKE:
            begin
                if (st_r.hold_cnt == 3'h0)
                begin
                    st_nxt.state = slpcg_pkg::SLPCG_ACTIVE;
                    st_nxt.mode = `SLPCG_IDLE_CODE;
                end
                else
                begin
                    st_nxt.hold_cnt = st_r.hold_cnt - 3'h1;
                end
            end
            default:
                st_nxt.state = slpcg_pkg::SLPCG_ACTIVE;
        endcase
        // Clock enables from the present mode and gates
        per_run = !deep_m;
        st_nxt.asleep = (st_nxt.state != slpcg_pkg::SLPCG_ACTIVE);
        st_nxt.clken.cpu = (st_nxt.state ==
            slpcg_pkg::SLPCG_ACTIVE);
        st_nxt.clken.per = per_run;
        st_nxt.clken.sys_src = !in_sleep || keep_sys;
        st_nxt.clken.rtc_src = !in_sleep || keep_rtc;
        // Gates freeze each peripheral; absent ones do nothing
        st_nxt.clken.usb = per_run &&
            !st_r.gen_gate[`SLPCG_GEN_USB];
        st_nxt.clken.aes = per_run &&
            !st_r.gen_gate[`SLPCG_GEN_AES];
        st_nxt.clken.rtc_bus = per_run &&
            !st_r.gen_gate[`SLPCG_GEN_RTC];
        st_nxt.clken.evt = per_run &&
            !st_r.gen_gate[`SLPCG_GEN_EVT];
        st_nxt.clken.dma = per_run &&
            !st_r.gen_gate[`SLPCG_GEN_DMA];
        st_nxt.clken.adc = per_run &&
            !st_r.ana_gate[`SLPCG_ANA_ADC];
        st_nxt.clken.cmp = per_run &&
            !st_r.ana_gate[`SLPCG_ANA_CMP];
        // Analog and pin power in deep sleep
        st_nxt.adc_off = deep_m;
        st_nxt.cmp_off = deep_m;
        st_nxt.vref_keep = cmp_uses_vref;
        st_nxt.bod_sampled = deep_m;
        st_nxt.inbuf_en = per_run;
    end

    // State register with clock enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
        end
        else if (clk_en)
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops, except pslverr tied to zero
    assign pready = st_r.pready;
    assign prdata = st_r.prdata;
    assign pslverr = 1'b0;
    assign clken = st_r.clken;
    assign adc_force_off = st_r.adc_off;
    assign cmp_force_off = st_r.cmp_off;
    assign vref_keep_on = st_r.vref_keep;
    assign bod_sampled = st_r.bod_sampled;
    assign pin_inbuf_en = st_r.inbuf_en;
    assign asleep = st_r.asleep;
endmodule : slpcg_top

// ### verif/slpcg_chk.sv
// Assertion checker for the sleep and clock gating block
module slpcg_chk #(
    parameter int HOLD_CYCLES = 4
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic sleep_instr,
    input wire logic debug_enabled,
    input wire slpcg_pkg::slpcg_clken_type clken,
    input wire logic adc_force_off,
    input wire logic cmp_force_off,
    input wire logic pin_inbuf_en,
    input wire logic asleep
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    reserved_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    inbuf_off_a: assert property ($past(!clken.per) && !clken.per
        |-> !pin_inbuf_en) else $error("input buffers on while stopped");
    adc_off_a: assert property ($past(!clken.per) && !clken.per
        && asleep |-> adc_force_off)
        else $error("converter not forced off");
    cmp_off_a: assert property ($past(!clken.per) && !clken.per
        && asleep |-> cmp_force_off)
        else $error("comparator not forced off");
    gated_stop_a: assert property ($past(!clken.per) && !clken.per
        |-> !(clken.usb || clken.aes || clken.evt || clken.dma))
        else $error("peripheral clock runs in deep sleep");
    sleep_cause_a: assert property ($rose(asleep) |-> $past(sleep_instr))
        else $error("sleep without instruction");
    wake_hold_a: assert property ($rose(clken.cpu)
        |-> $past(!clken.cpu, HOLD_CYCLES)) else $error("wake hold short");
    debug_clock_a: assert property (asleep && $past(asleep)
        && debug_enabled |-> clken.sys_src) else $error("main clock stopped");
endmodule : slpcg_chk

bind slpcg_top slpcg_chk #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .prdata(prdata), .sleep_instr(sleep_instr),
    .debug_enabled(debug_enabled), .clken(clken),
    .adc_force_off(adc_force_off), .cmp_force_off(cmp_force_off),
    .pin_inbuf_en(pin_inbuf_en), .asleep(asleep));

// ### verif/slpcg_core_model.sv
// Core model issuing the sleep instruction
module slpcg_core_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic asleep,
    output logic sleep_instr
);
    timeunit 1ns;
    timeprecision 1ns;

    // One-cycle instruction, never while already asleep
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sleep_instr <= 1'b0;
        else
            sleep_instr <= req && !asleep && !sleep_instr;
    end
endmodule : slpcg_core_model

// ### verif/tb.sv
// Testbench for the sleep and clock gating block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic req, sleep_instr, dma_enabled, cmp_uses_vref, debug_enabled;
    logic irq_any, irq_async_port, irq_addr_match, irq_usb_resume, irq_rtc;
    logic adc_force_off, cmp_force_off, vref_keep_on, bod_sampled;
    logic pin_inbuf_en, asleep;
    slpcg_pkg::slpcg_clken_type clken;
    int bad_count, tests_run;

    slpcg_top u_slpcg_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .sleep_instr(sleep_instr),
        .dma_enabled(dma_enabled), .cmp_uses_vref(cmp_uses_vref),
        .debug_enabled(debug_enabled), .irq_any(irq_any),
        .irq_async_port(irq_async_port), .irq_addr_match(irq_addr_match),
        .irq_usb_resume(irq_usb_resume), .irq_rtc(irq_rtc), .clken(clken),
        .adc_force_off(adc_force_off), .cmp_force_off(cmp_force_off),
        .vref_keep_on(vref_keep_on), .bod_sampled(bod_sampled),
        .pin_inbuf_en(pin_inbuf_en), .asleep(asleep));
    slpcg_core_model u_slpcg_core_model (.pclk(pclk), .presetn(presetn),
        .req(req), .asleep(asleep), .sleep_instr(sleep_instr));

    // 20 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        if (g !== e)
            bad_count++;
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    // One APB transfer; read data lands in rd
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        chk(n < 20, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic t_regs();
        logic [11:0] ad [3] = '{12'h000, 12'h010, 12'h014};
        logic [31:0] mk [3] = '{32'h0F, 32'h57, 32'h03};
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, ad[i], 32'h0);
            chk(rd, 32'h0);
            apb(1'b1, ad[i], 32'hFF);
            apb(1'b0, ad[i], 32'h0);
            chk(rd, mk[i]);
        end
        apb(1'b1, 12'h030, 32'hFF);
        apb(1'b0, 12'h030, 32'h0);
        chk(rd, 32'h0);
        repeat (2) @(posedge pclk);
        chk({21'h0, clken}, 32'h6C0);
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h014, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        repeat (2) @(posedge pclk);
        chk({21'h0, clken}, 32'h7FF);
        $display("register test done");
    endtask : t_regs

    task automatic t_dma();
        dma_enabled <= 1'b1;
        apb(1'b1, 12'h010, 32'h01);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        dma_enabled <= 1'b0;
        apb(1'b1, 12'h010, 32'h01);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, 12'h010, 32'h0);
        $display("dma gate test done");
    endtask : t_dma

    // Sleep in mode m, check domains, wake by port interrupt
    task automatic t_sleep(input logic [2:0] m, input logic sleep_enable_bit,
        input logic s, input logic [2:0] c, input logic dbg);
        int n;
        debug_enabled <= dbg;
        cmp_uses_vref <= m[0];
        apb(1'b1, 12'h000, {28'h0, m, sleep_enable_bit});
        req <= 1'b1;
        @(posedge pclk);
        req <= 1'b0;
        repeat (4) @(posedge pclk);
        chk({asleep, clken.cpu, clken.per, clken.rtc_src, clken.sys_src,
            adc_force_off, cmp_force_off, pin_inbuf_en},
            {s, !s, c, s && !c[2], s && !c[2], c[2]});
        chk({pslverr, bod_sampled, vref_keep_on},
            {1'b0, s && !c[2], m[0]});
        if (s)
        begin
            irq_async_port <= 1'b1;
            n = 0;
            do
            begin
                @(posedge pclk);
                n++;
            end
            while (clken.cpu !== 1'b1 && n < 30);
            chk(n >= 5 && n <= 10, 1'b1);
            irq_async_port <= 1'b0;
        end
        apb(1'b1, 12'h000, 32'h0);
        $display("sleep test mode %0d done", m);
    endtask : t_sleep

    // Sleep instruction while state is frozen by the clock enable
    task automatic t_freeze();
        apb(1'b1, 12'h000, 32'h1);
        @(posedge pclk);
        clk_en <= 1'b0;
        req <= 1'b1;
        @(posedge pclk);
        req <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(asleep, 1'b0);
        clk_en <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(asleep, 1'b0);
        apb(1'b1, 12'h000, 32'h0);
        $display("clock enable test done");
    endtask : t_freeze

    initial
    begin
        {presetn, psel, penable, pwrite, req, dma_enabled} = 6'h0;
        {cmp_uses_vref, debug_enabled, irq_any, irq_async_port} = 4'h0;
        {irq_addr_match, irq_usb_resume, irq_rtc} = 3'h0;
        clk_en = 1'b1;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_dma();
        t_sleep(3'h0, 1'b1, 1'b1, 3'b111, 1'b0);
        t_sleep(3'h1, 1'b1, 1'b0, 3'b111, 1'b0);
        t_sleep(3'h2, 1'b1, 1'b1, 3'b000, 1'b0);
        t_sleep(3'h3, 1'b1, 1'b1, 3'b010, 1'b0);
        t_sleep(3'h4, 1'b1, 1'b0, 3'b111, 1'b0);
        t_sleep(3'h5, 1'b1, 1'b0, 3'b111, 1'b0);
        t_sleep(3'h6, 1'b1, 1'b1, 3'b001, 1'b0);
        t_sleep(3'h7, 1'b1, 1'b1, 3'b011, 1'b0);
        t_sleep(3'h3, 1'b0, 1'b0, 3'b111, 1'b0);
        t_sleep(3'h2, 1'b1, 1'b1, 3'b001, 1'b1);
        t_freeze();
        finish_test();
    end

    // Watchdog: tests need about 250 cycles, allow 10000
    initial
    begin
        #500000;
        bad_count++;
        finish_test();
    end
endmodule : tb
